/* logic/pcu_cfg.svh */
// Register offsets, field positions, reset values and widths of the channel counter block
`ifndef PCU_CFG_SVH
`define PCU_CFG_SVH

// Widths
`define PCU_CNT_W         16
`define PCU_ADDR_W        8
`define PCU_DATA_W        32
`define PCU_PRESC_W       10
`define PCU_DIV_W         8
`define PCU_SEL_W         4

// Register byte offsets, one aligned word each
`define PCU_OFS_MODE      8'h00
`define PCU_OFS_DUTY      8'h04
`define PCU_OFS_PERIOD    8'h08
`define PCU_OFS_COUNT     8'h0C
`define PCU_OFS_UPDATE    8'h10
`define PCU_OFS_ENABLE    8'h14
`define PCU_OFS_DISABLE   8'h18
`define PCU_OFS_STATUS    8'h1C
`define PCU_OFS_DIVIDER   8'h20

// Mode register fields
`define PCU_MODE_SEL_LSB  0
`define PCU_MODE_ALG_BIT  8
`define PCU_MODE_POL_BIT  9
`define PCU_MODE_UPD_BIT  10

// Divider register fields
`define PCU_LINEAR_DIVIDER_A_LSB      0
`define PCU_LINEAR_DIVIDER_B_LSB      8

// Source selector codes
`define PCU_SEL_PRESC_MAX 4'hA
`define PCU_SEL_LINEAR_DIVIDER_A      4'h b
`define PCU_SEL_LINEAR_DIVIDER_B      4'h c

// Reset values
`define PCU_RST_MODE      11'h000
`define PCU_RST_DUTY      16'h0000
`define PCU_RST_PERIOD    16'h0000
`define PCU_RST_DIV       8'h00

`endif

/* logic/pcu_pkg.sv */
// Types shared by the channel counter block
`include "pcu_cfg.svh"

package pcu_pkg;

   // One register bus request
   typedef struct packed {
      logic [`PCU_ADDR_W-1:0] addr;   // Byte address
      logic [`PCU_DATA_W-1:0] wdata;  // Write data
      logic                   wr;     // Write strobe
      logic                   rd;     // Read strobe
   } pcu_bus_req_t;

   // Whole state of the channel
   typedef struct packed {
      logic [`PCU_SEL_W-1:0]   src_sel;     // Counter source selector
      logic                    align_ctr;   // Center aligned when set
      logic                    pol_high;    // Waveform starts high
      logic                    upd_period;  // Pending value targets period
      logic [`PCU_CNT_W-1:0]   duty;        // Active duty value
      logic [`PCU_CNT_W-1:0]   period;      // Active period value
      logic [`PCU_CNT_W-1:0]   pend;        // Pending update value
      logic                    pend_vld;    // Pending value waiting
      logic                    enabled;     // Channel running
      logic [`PCU_CNT_W-1:0]   cnt;         // Channel counter
      logic                    down;        // Center mode counting down
      logic [`PCU_PRESC_W-1:0] presc;       // Free running prescaler
      logic [`PCU_DIV_W-1:0]   linear_divider_a_ratio;  // Linear divider A ratio
      logic [`PCU_DIV_W-1:0]   linear_divider_b_ratio;  // Linear divider B ratio
      logic [`PCU_DIV_W-1:0]   linear_divider_a_cnt;    // Divider A count
      logic [`PCU_DIV_W-1:0]   linear_divider_b_cnt;    // Divider B count
      logic                    pstart;      // Period start pulse
      logic                    wave;        // Waveform output
      logic [`PCU_DATA_W-1:0]  rdata;       // Read data
   } pcu_state_t;

endpackage

/* logic/pcu_channel.sv */
// Channel counter with prescaler, dividers and double-buffered duty/period update
`timescale 1ns/1ps
`include "pcu_cfg.svh"

module pcu_channel
   import pcu_pkg::*;
(
   input  wire logic                   sys_clk_in,      // Master clock, 20 MHz
   input  wire logic                   arst_n_in,       // Async reset, active low
   input  wire pcu_bus_req_t           bus_req_in,      // Register bus request
   output logic [`PCU_DATA_W-1:0]      bus_rdata_out,   // Read data, cycle after read
   output logic                        wave_out,        // Channel waveform
   output logic                        period_start_out // One pulse per period start
);

   pcu_state_t s_q;                           // Registered state
   pcu_state_t s_d;                           // Next state

   logic [`PCU_PRESC_W-1:0] presc_mask;       // Low prescaler bits for the chosen ratio
   logic                    tick_presc;       // Prescaler tick
   logic                    tick_linear_divider_a;        // Divider A tick
   logic                    tick_linear_divider_b;        // Divider B tick
   logic                    tick;             // Counter source tick
   logic                    wr_en;            // Enable register written with bit set
   logic [`PCU_CNT_W-1:0]   cnt_inc;          // Counter plus one

   // Outputs straight from state flops
   assign bus_rdata_out    = s_q.rdata;
   assign wave_out         = s_q.wave;
   assign period_start_out = s_q.pstart;

   // Prescaler mask: ratio two to the selector, all ones marks the tick
   assign presc_mask = `PCU_PRESC_W'((11'h001 << s_q.src_sel) - 11'h001);

   // Source tick select
   always_comb begin
      tick_presc = ((s_q.presc & presc_mask) == presc_mask);
      // A zero ratio stops the divider, so the channel simply holds
      tick_linear_divider_a  = (s_q.linear_divider_a_ratio != '0) && (s_q.linear_divider_a_cnt == s_q.linear_divider_a_ratio - 8'h01);
      tick_linear_divider_b  = (s_q.linear_divider_b_ratio != '0) && (s_q.linear_divider_b_cnt == s_q.linear_divider_b_ratio - 8'h01);
      if (s_q.src_sel <= `PCU_SEL_PRESC_MAX) begin
         tick = tick_presc;
      end else if (s_q.src_sel == `PCU_SEL_LINEAR_DIVIDER_A) begin
         tick = tick_linear_divider_a;
      end else if (s_q.src_sel == `PCU_SEL_LINEAR_DIVIDER_B) begin
         tick = tick_linear_divider_b;
      end else begin
         tick = 1'b0;                                                        // Reserved code, no count
      end
   end

   assign wr_en   = bus_req_in.wr && (bus_req_in.addr == `PCU_OFS_ENABLE) && bus_req_in.wdata[0];
   assign cnt_inc = s_q.cnt + 16'h0001;

   // Next state
   always_comb begin
      s_d        = s_q;
      s_d.rdata  = '0;
      s_d.pstart = 1'b0;

      // Free running dividers, independent of the channel enable
      s_d.presc = s_q.presc + 10'h001;
      if (tick_linear_divider_a || s_q.linear_divider_a_ratio == '0) begin
         s_d.linear_divider_a_cnt = '0;
      end else begin
         s_d.linear_divider_a_cnt = s_q.linear_divider_a_cnt + 8'h01;
      end
      if (tick_linear_divider_b || s_q.linear_divider_b_ratio == '0) begin
         s_d.linear_divider_b_cnt = '0;
      end else begin
         s_d.linear_divider_b_cnt = s_q.linear_divider_b_cnt + 8'h01;
      end

      // Counter
      if (s_q.enabled && tick) begin
         if (!s_q.align_ctr) begin
            // Left aligned: period ticks from zero back to zero
            if (cnt_inc >= s_q.period) begin
               s_d.cnt    = '0;
               s_d.pstart = 1'b1;
            end else begin
               s_d.cnt = cnt_inc;
            end
         end else if (!s_q.down) begin
            // Center aligned, rising half
            if (cnt_inc >= s_q.period) begin
               s_d.cnt  = s_q.period;
               s_d.down = 1'b1;
            end else begin
               s_d.cnt = cnt_inc;
            end
         end else begin
            // Center aligned, falling half; reaching zero ends the period
            if (s_q.cnt <= 16'h0001) begin
               s_d.cnt    = '0;
               s_d.down   = 1'b0;
               s_d.pstart = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
      end

      // Pending value lands only at a period start, never mid-period
      if (s_d.pstart && s_q.pend_vld) begin
         s_d.pend_vld = 1'b0;
         if (s_q.upd_period) begin
            s_d.period = s_q.pend;
         end else begin
            s_d.duty = s_q.pend;
         end
      end

      // Register writes
      if (bus_req_in.wr) begin
         case (bus_req_in.addr)
            `PCU_OFS_MODE: begin
               s_d.src_sel    = bus_req_in.wdata[`PCU_MODE_SEL_LSB +: `PCU_SEL_W];
               s_d.align_ctr  = bus_req_in.wdata[`PCU_MODE_ALG_BIT];
               s_d.pol_high   = bus_req_in.wdata[`PCU_MODE_POL_BIT];
               s_d.upd_period = bus_req_in.wdata[`PCU_MODE_UPD_BIT];
            end
            `PCU_OFS_DUTY: begin
               // Direct load only while stopped; running changes go through the update register
               if (!s_q.enabled) begin
                  s_d.duty = bus_req_in.wdata[`PCU_CNT_W-1:0];
               end
            end
            `PCU_OFS_PERIOD: begin
               if (!s_q.enabled) begin
                  s_d.period = bus_req_in.wdata[`PCU_CNT_W-1:0];
               end
            end
            `PCU_OFS_COUNT: begin
               s_d.cnt = s_d.cnt;                                            // Read-only, write dropped
            end
            `PCU_OFS_UPDATE: begin
               s_d.pend     = bus_req_in.wdata[`PCU_CNT_W-1:0];
               s_d.pend_vld = 1'b1;
            end
            `PCU_OFS_ENABLE: begin
               if (bus_req_in.wdata[0]) begin
                  s_d.enabled = 1'b1;
                  s_d.cnt     = '0;
                  s_d.down    = 1'b0;
               end
            end
            `PCU_OFS_DISABLE: begin
               if (bus_req_in.wdata[0]) begin
                  s_d.enabled = 1'b0;
               end
            end
            `PCU_OFS_DIVIDER: begin
               s_d.linear_divider_a_ratio = bus_req_in.wdata[`PCU_LINEAR_DIVIDER_A_LSB +: `PCU_DIV_W];
               s_d.linear_divider_b_ratio = bus_req_in.wdata[`PCU_LINEAR_DIVIDER_B_LSB +: `PCU_DIV_W];
            end
            default: begin
               s_d.rdata = '0;                                               // Unmapped write ignored
            end
         endcase
      end

      // Register reads, answer in the next cycle
      if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            `PCU_OFS_MODE: begin
               s_d.rdata = {21'h00_0000, s_q.upd_period, s_q.pol_high, s_q.align_ctr,
                            4'h0, s_q.src_sel};
            end
            `PCU_OFS_DUTY: begin
               s_d.rdata = {16'h0000, s_q.duty};
            end
            `PCU_OFS_PERIOD: begin
               s_d.rdata = {16'h0000, s_q.period};
            end
            `PCU_OFS_COUNT: begin
               s_d.rdata = {16'h0000, s_q.cnt};
            end
            `PCU_OFS_STATUS: begin
               s_d.rdata = {28'h000_0000, s_q.wave, s_q.down, s_q.pend_vld, s_q.enabled};
            end
            `PCU_OFS_DIVIDER: begin
               s_d.rdata = {16'h0000, s_q.linear_divider_b_ratio, s_q.linear_divider_a_ratio};
            end
            default: begin
               s_d.rdata = '0;                                               // Write-only and unmapped read zero
            end
         endcase
      end

      // Waveform: starting level for the active part, inverse after the duty point
      if (!s_d.enabled) begin
         s_d.wave = 1'b0;
      end else if (s_d.cnt < s_d.duty) begin
         s_d.wave = s_d.pol_high;
      end else begin
         s_d.wave = !s_d.pol_high;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_q            <= '0;
         s_q.duty       <= `PCU_RST_DUTY;
         s_q.period     <= `PCU_RST_PERIOD;
         s_q.linear_divider_a_ratio <= `PCU_RST_DIV;
         s_q.linear_divider_b_ratio <= `PCU_RST_DIV;
      end else begin
         s_q <= s_d;
      end
   end

   // Checks, all on the master clock and quiet during reset

   // Prescaler tick lands on a power of two boundary
   AST_PRESC_TICK: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.src_sel == 4'h3 && tick) |-> (s_q.presc[2:0] == 3'h7))
      else $error("Prescaler tick off its power of two boundary");

   // Counter only moves on a source tick or a bus write
   AST_TICK_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.enabled && !tick && !bus_req_in.wr) |=> $stable(s_q.cnt))
      else $error("Counter moved without a source tick");

   // Center period ends only after the falling half
   AST_CENTER_END: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.pstart && s_q.align_ctr && !$past(wr_en)) |-> ($past(s_q.down) && s_q.cnt == '0))
      else $error("Center period ended without a falling half");

   // Divider A spacing, once the ratio has settled for three cycles
   AST_LINEAR_DIVIDER_A_RATE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (tick_linear_divider_a && s_q.linear_divider_a_ratio == 8'h03 && $past(s_q.linear_divider_a_ratio, 3) == 8'h03 && !$past(bus_req_in.wr))
      |-> $past(tick_linear_divider_a, 3))
      else $error("Divider A tick spacing wrong");

   // Enable clears the counter
   AST_ENABLE_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      wr_en |=> (s_q.cnt == '0 && s_q.enabled))
      else $error("Counter not cleared on enable");

   // Stopped counter holds, whatever software writes except an enable
   AST_IDLE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (!s_q.enabled && !wr_en) |=> $stable(s_q.cnt))
      else $error("Stopped counter moved");

   // Left mode wraps to zero at the period value
   AST_LEFT_WRAP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.enabled && tick && !s_q.align_ctr && cnt_inc >= s_q.period && !bus_req_in.wr)
      |=> (s_q.cnt == '0 && s_q.pstart))
      else $error("Left counter did not wrap at period");

   // Period start pulse always comes with a zero count
   AST_PSTART_ZERO: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      s_q.pstart |-> (s_q.cnt == '0))
      else $error("Period start with a nonzero count");

   // Counter view answers in the cycle after the read
   AST_VIEW_READ: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (bus_req_in.rd && bus_req_in.addr == `PCU_OFS_COUNT) |=> (bus_rdata_out == {16'h0000, $past(s_q.cnt)}))
      else $error("Counter view read wrong");

   // Read data stands one cycle only
   AST_READ_IDLE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !bus_req_in.rd |=> (bus_rdata_out == '0))
      else $error("Read data without a read");

   // Active values never change inside a running period
   AST_NO_MIDPERIOD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.enabled && !s_d.pstart && !wr_en) |=> $stable(s_q.duty) && $stable(s_q.period))
      else $error("Active value changed mid period");

   // Pending value waits for the period start
   AST_UPDATE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.pend_vld && !s_d.pstart) |=> s_q.pend_vld)
      else $error("Pending value lost before period start");

   // Only the low half of the update word is kept
   AST_PEND_LOW16: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (bus_req_in.wr && bus_req_in.addr == `PCU_OFS_UPDATE)
      |=> (s_q.pend == $past(bus_req_in.wdata[15:0]) && s_q.pend_vld))
      else $error("Pending value not low sixteen bits");

   // Duty load at period start
   AST_DUTY_LOAD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_d.pstart && s_q.pend_vld && !s_q.upd_period) |=> (s_q.duty == $past(s_q.pend)))
      else $error("Duty not loaded at period start");

   // Pending flag drops once the value has landed
   AST_PEND_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_d.pstart && s_q.pend_vld && !(bus_req_in.wr && bus_req_in.addr == `PCU_OFS_UPDATE))
      |=> !s_q.pend_vld)
      else $error("Pending flag stayed after load");

   // Period load at period start
   AST_PERIOD_LOAD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_d.pstart && s_q.pend_vld && s_q.upd_period) |=> (s_q.period == $past(s_q.pend)))
      else $error("Period not loaded at period start");

   // Center mode turns at the period value
   AST_CENTER_TURN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (s_q.enabled && tick && s_q.align_ctr && !s_q.down && cnt_inc >= s_q.period && !bus_req_in.wr)
      |=> (s_q.down && s_q.cnt == $past(s_q.period)))
      else $error("Center counter did not turn at period");

   // Main scenarios reached
   COV_LEFT_PERIOD:   cover property (@(posedge sys_clk_in) s_q.pstart && !s_q.align_ctr);
   COV_DUTY_UPDATE:   cover property (@(posedge sys_clk_in) s_d.pstart && s_q.pend_vld && !s_q.upd_period);
   COV_CENTER_PERIOD: cover property (@(posedge sys_clk_in) s_q.pstart && s_q.align_ctr);
   COV_PERIOD_UPDATE: cover property (@(posedge sys_clk_in) s_d.pstart && s_q.pend_vld && s_q.upd_period);
   COV_LINEAR_DIVIDER_B_COUNT:    cover property (@(posedge sys_clk_in) s_q.src_sel == `PCU_SEL_LINEAR_DIVIDER_B && tick && s_q.enabled);

endmodule

/* tb/test_pwm_channel_counter_update.sv */
// Self-checking bench of the channel counter and double-buffered update path
`timescale 1ns/1ps
`include "pcu_cfg.svh"

module test_pwm_channel_counter_update
   import pcu_pkg::*;
;
   logic         sys_clk_in  = 1'b0; // Master clock, 20 MHz
   logic         arst_n_in   = 1'b0; // Reset, active low
   pcu_bus_req_t bus_req_in  = '0;   // Register bus request
   logic [31:0]  bus_rdata_out;      // Read data
   logic         wave_out;           // Waveform
   logic         period_start_out;   // Period start pulse
   int           error_cnt   = 0;    // Mismatches
   int           checks_done = 0;    // Comparisons made
   int           cyc         = 0;    // Cycle count for the hang guard
   logic [31:0]  rv;                 // Last read value
   logic [31:0]  c1;                 // First counter sample

   // Half period of 25 ns
   always #25 sys_clk_in = ~sys_clk_in;

   pcu_channel DUT (
      .sys_clk_in       (sys_clk_in),
      .arst_n_in        (arst_n_in),
      .bus_req_in       (bus_req_in),
      .bus_rdata_out    (bus_rdata_out),
      .wave_out         (wave_out),
      .period_start_out (period_start_out)
   );

   // Verdict and end of run
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard, far above the longest expected run
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         $display("Error at %0t: run did not finish", $time);
         end_of_test();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      bus_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      bus_req_in <= '0;
   endtask

   // One-cycle read strobe, data taken in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      bus_req_in <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      bus_req_in <= '0;
      @(negedge sys_clk_in);
      d = bus_rdata_out;
   endtask

   // Stop, program mode, duty and period, then enable
   task automatic cfg(input logic [3:0] sel, input logic ctr, input logic upd,
                      input logic [15:0] per, input logic [15:0] dty);
      wr(`PCU_OFS_DISABLE, 32'h0000_0001);
      wr(`PCU_OFS_MODE, {21'h00_0000, upd, 1'b0, ctr, 4'h0, sel});
      wr(`PCU_OFS_DUTY, {16'h0000, dty});
      wr(`PCU_OFS_PERIOD, {16'h0000, per});
      wr(`PCU_OFS_ENABLE, 32'h0000_0001);
   endtask

   // Bounded wait for a period start, sampled mid-cycle
   task automatic wait_start();
      int n;
      n = 0;
      @(negedge sys_clk_in);
      while (period_start_out !== 1'b1 && n < 5000) begin
         @(negedge sys_clk_in);
         n++;
      end
      if (n >= 5000) begin
         chk({31'h0, period_start_out}, 32'h0000_0001, "period start missing");
      end
   endtask

   // Cycles between two starts and high cycles within; negative skips the high check
   task automatic measure(input int exp_gap, input int exp_high);
      int g;
      int h;
      g = 0;
      h = 0;
      wait_start();
      do begin
         if (wave_out === 1'b1) begin
            h++;
         end
         g++;
         @(negedge sys_clk_in);
      end while (period_start_out !== 1'b1 && g < 5000);
      chk(g, exp_gap, "period length");
      if (exp_high >= 0) begin
         chk(h, exp_high, "high cycles");
      end
   endtask

   // Register values after reset, write-only and unmapped reads give 0
   task automatic t_reset();
      logic [7:0] ofs [8];
      ofs = '{`PCU_OFS_MODE, `PCU_OFS_DUTY, `PCU_OFS_PERIOD, `PCU_OFS_COUNT,
              `PCU_OFS_UPDATE, `PCU_OFS_STATUS, `PCU_OFS_DIVIDER, 8'h24};
      foreach (ofs[i]) begin
         rd(ofs[i], rv);
         chk(rv, 32'h0000_0000, "reset read");
      end
   endtask

   // Every prescaler step, left aligned, period 2 duty 1
   task automatic t_presc();
      for (int n = 0; n <= 10; n++) begin
         cfg(n[3:0], 1'b0, 1'b0, 16'h0002, 16'h0001);
         measure(2 << n, 1 << n);
      end
   endtask

   // Center aligned runs twice as long, undivided and over 4
   task automatic t_center();
      cfg(4'h0, 1'b1, 1'b0, 16'h0003, 16'h0001);
      measure(6, -1);
      cfg(4'h2, 1'b1, 1'b0, 16'h0003, 16'h0001);
      measure(24, -1);
   endtask

   // Linear dividers, ratio A 3 left, ratio B 5 center
   task automatic t_div();
      wr(`PCU_OFS_DIVIDER, 32'h0000_0503);
      cfg(`PCU_SEL_LINEAR_DIVIDER_A, 1'b0, 1'b0, 16'h0004, 16'h0001);
      measure(12, 9);
      cfg(`PCU_SEL_LINEAR_DIVIDER_B, 1'b1, 1'b0, 16'h0004, 16'h0001);
      measure(40, -1);
   endtask

   // Counter ignores writes; a repeated enable clears it
   task automatic t_count();
      cfg(4'h0, 1'b0, 1'b0, 16'h03E8, 16'h0000);
      repeat (300) @(posedge sys_clk_in);
      rd(`PCU_OFS_COUNT, c1);
      wr(`PCU_OFS_COUNT, 32'h0000_0000);
      rd(`PCU_OFS_COUNT, rv);
      chk(rv, c1 + 32'h0000_0004, "count after write");
      wr(`PCU_OFS_ENABLE, 32'h0000_0001);
      rd(`PCU_OFS_COUNT, rv);
      chk(rv, 32'h0000_0001, "count after enable");
   endtask

   // Pending value lands at the next start only, upper half dropped
   task automatic t_update();
      cfg(4'h0, 1'b0, 1'b0, 16'h000A, 16'h0002);
      wait_start();
      wr(`PCU_OFS_UPDATE, 32'hABCD_0007);
      rd(`PCU_OFS_DUTY, rv);
      chk(rv, 32'h0000_0002, "duty before start");
      wait_start();
      rd(`PCU_OFS_DUTY, rv);
      chk(rv, 32'h0000_0007, "duty after start");
      measure(10, 3);
      wr(`PCU_OFS_MODE, 32'h0000_0400);
      wait_start();
      wr(`PCU_OFS_UPDATE, 32'hFFFF_0008);
      rd(`PCU_OFS_PERIOD, rv);
      chk(rv, 32'h0000_000A, "period before start");
      measure(8, 1);
      rd(`PCU_OFS_PERIOD, rv);
      chk(rv, 32'h0000_0008, "period after start");
   endtask

   // Start-high polarity, refused direct load, reserved source, status with a value pending
   task automatic t_mode();
      cfg(4'h0, 1'b0, 1'b0, 16'h0004, 16'h0001);
      wr(`PCU_OFS_MODE, 32'h0000_0200);
      measure(4, 1);
      wr(`PCU_OFS_DUTY, 32'h0000_0003);
      rd(`PCU_OFS_DUTY, rv);
      chk(rv, 32'h0000_0001, "duty direct write while running");
      cfg(4'hD, 1'b0, 1'b0, 16'h0004, 16'h0001);
      repeat (20) @(posedge sys_clk_in);
      rd(`PCU_OFS_COUNT, rv);
      chk(rv, 32'h0000_0000, "count on reserved source");
      wr(`PCU_OFS_DISABLE, 32'h0000_0001);
      wr(`PCU_OFS_UPDATE, 32'h0000_0002);
      rd(`PCU_OFS_STATUS, rv);
      chk(rv, 32'h0000_0002, "status with value pending");
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_presc();
      t_center();
      t_div();
      t_count();
      t_update();
      t_mode();
      end_of_test();
   end

endmodule
